/* rtl/pcn_top.sv */
// Port change notifier: APB registers, pin synchronisers, mismatch and edge detection
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pcn_map.svh"
module pcn_top
  import pcn_pkg::*;
#(
  parameter int NPINS = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Port pins, asynchronous
  input wire logic [NPINS-1:0] i_pins,
  // Requests
  output logic o_cn_req,
  output logic o_irq
);

  // Pins are sampled on i_clk, so detection needs the clock but never bus traffic
  // A pin pulse shorter than about one clock period can slip past the synchroniser
  // Pin and control registers are 16 bits wide whatever NPINS is
  // Pins above NPINS read zero outside the direction register and never raise an event
  localparam logic [15:0] PIN_MASK = 16'((17'h1 << NPINS) - 17'h1); // Implemented pins

  // Refuse widths the 16-bit registers cannot hold
  initial begin
    if (NPINS < 1 || NPINS > 16) begin
      $error("pcn_top NPINS must lie between 1 and 16");
    end
  end

  // Software-visible registers and the port-read snapshot
  logic [15:0] ctrl_ff; // Control register
  logic [15:0] pin_en_ff; // Primary per-pin enables
  logic [15:0] edge_sel_ff; // Per-pin edge selects
  logic [15:0] dir_ff; // Output disable, 1 means input
  logic [15:0] last_read_ff; // Pin levels at last port read
  logic [15:0] mismatch_ff; // Changed since last read
  logic [`PCN_IRQ_W-1:0] irq_stat_ff; // Sticky interrupt causes
  logic [`PCN_IRQ_W-1:0] irq_mask_ff; // Interrupt mask
  // Bus answer flops
  logic [31:0] prdata_ff; // Read data, loaded in setup
  logic slverr_ff; // Unmapped address flag, loaded in setup
  // Pin path and detection
  logic [NPINS-1:0] pins_sync; // Synchronised pins
  logic [15:0] pins16; // Synchronised pins, register width
  logic [15:0] flags; // Edge event flags from cells
  logic [15:0] flag_set; // Edge events this clock
  logic [15:0] flag_clr; // Flag clear strobes
  logic [15:0] armed; // Pin may raise an event
  logic [15:0] nxt_mismatch; // Next mismatch state
  logic [15:0] mism_new; // Mismatch bits rising now
  logic [`PCN_IRQ_W-1:0] irq_evt; // Interrupt events this clock
  // Bus decode
  logic setup; // APB setup phase
  logic wr_acc; // APB write completes
  logic rd_acc; // APB read completes
  logic port_rd; // Port input read completes
  logic mapped; // Address hits a register
  logic [31:0] rdata_mux; // Read data selected by address
  pcn_cfg_t cfg; // Configuration bundle

  // Bundle kept together so the detectors see one coherent set of controls
  // Gather configuration for the detectors
  always_comb begin
    cfg.on = ctrl_ff[`PCN_CTRL_ON_BIT];
    cfg.style = ctrl_ff[`PCN_CTRL_STYLE_BIT]; // [R14]
    cfg.pin_en = pin_en_ff;
    cfg.edge_sel = edge_sel_ff;
    cfg.dir = dir_ff;
  end

  // Crossing costs two clocks of latency on every pin change
  // Pins pass two flops before any detection looks at them
  pcn_sync #(
    .W(NPINS)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(i_pins),
    .o_sync(pins_sync)
  );

  assign pins16 = 16'(pins_sync) & PIN_MASK;

  // The slave never stalls; every access phase ends at its first edge
  // Unmapped addresses answer with an error and change nothing
  // APB phase decode; zero wait states, so every access phase completes
  assign setup = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite & mapped;
  assign rd_acc = i_psel & i_penable & ~i_pwrite & mapped;
  assign port_rd = rd_acc & (i_paddr == `PCN_OFS_PORT_IN);

  // Decode is purely combinational on the held address
  // Address decode
  always_comb begin
    case (i_paddr)
      `PCN_OFS_CTRL, `PCN_OFS_PIN_EN, `PCN_OFS_EDGE_SEL, `PCN_OFS_MISMATCH,
      `PCN_OFS_FLAGS, `PCN_OFS_PORT_IN, `PCN_OFS_DIR, `PCN_OFS_IRQ_MASK,
      `PCN_OFS_IRQ_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Word order: control, pin enables, edge selects, mismatch status (read only),
  // Event flags (write one to clear), port input (a read takes the snapshot),
  // Direction (one means input), interrupt mask,
  // Interrupt status (write one to clear)
  // Read data selection; unimplemented bits read zero
  always_comb begin
    case (i_paddr)
      `PCN_OFS_CTRL: rdata_mux = {16'h0000, ctrl_ff};
      `PCN_OFS_PIN_EN: rdata_mux = {16'h0000, pin_en_ff};
      `PCN_OFS_EDGE_SEL: rdata_mux = {16'h0000, edge_sel_ff};
      `PCN_OFS_MISMATCH: rdata_mux = {16'h0000, mismatch_ff};
      `PCN_OFS_FLAGS: rdata_mux = {16'h0000, flags};
      `PCN_OFS_PORT_IN: rdata_mux = {16'h0000, pins16};
      `PCN_OFS_DIR: rdata_mux = {16'h0000, dir_ff};
      `PCN_OFS_IRQ_MASK: rdata_mux = {30'h00000000, irq_mask_ff};
      `PCN_OFS_IRQ_STAT: rdata_mux = {30'h00000000, irq_stat_ff};
      default: rdata_mux = 32'h00000000;
    endcase
  end

  // Read data and error captured in setup so the outputs come from flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      // Writes read back zero so stale data never shows on the bus
      prdata_ff <= i_pwrite ? 32'h00000000 : rdata_mux;
      slverr_ff <= ~mapped;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = 1'b1;
  assign o_pslverr = slverr_ff & i_psel & i_penable;

  // A control write replaces both kept bits together
  // Control register: only the enable and style bits are kept
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_ff <= `PCN_RST_CTRL;
    end else if (wr_acc && i_paddr == `PCN_OFS_CTRL) begin
      // Unimplemented bits are dropped so they read zero
      ctrl_ff <= 16'h0000;
      ctrl_ff[`PCN_CTRL_ON_BIT] <= i_pwdata[`PCN_CTRL_ON_BIT]; // [R1]
      ctrl_ff[`PCN_CTRL_STYLE_BIT] <= i_pwdata[`PCN_CTRL_STYLE_BIT]; // [R8]
    end
  end

  // Enables are plain read and write
  // Per-pin primary enables
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_en_ff <= `PCN_RST_PIN_EN;
    end else if (wr_acc && i_paddr == `PCN_OFS_PIN_EN) begin
      // Bits of absent pins stay zero
      pin_en_ff <= i_pwdata[15:0] & PIN_MASK; // [R3]
    end
  end

  // In edge style an edge select bit with the enable clear picks falling edges
  // Per-pin edge selects, one bit each
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_sel_ff <= `PCN_RST_EDGE_SEL;
    end else if (wr_acc && i_paddr == `PCN_OFS_EDGE_SEL) begin
      // Bits of absent pins stay zero
      edge_sel_ff <= i_pwdata[15:0] & PIN_MASK; // [R12]
    end
  end

  // Reset makes every pin an input, matching a port that drives nothing
  // Direction copy; pulls are software's business and not handled here
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_ff <= `PCN_RST_DIR;
    end else if (wr_acc && i_paddr == `PCN_OFS_DIR) begin
      // All 16 bits kept; absent pins are masked where detection arms
      dir_ff <= i_pwdata[15:0];
    end
  end

  // Output pins are ignored rather than blocked, so turning one back gives no edge event
  // A pin is armed only when the port is on and the pin is an input
  assign armed = {16{cfg.on}} & cfg.dir & PIN_MASK; // [R1] [R11]

  // Writing zero leaves a flag alone, so clearing one pin never loses another
  // Flags clear by writing one to the bit
  assign flag_clr = (wr_acc && i_paddr == `PCN_OFS_FLAGS) ? i_pwdata[15:0] : 16'h0000; // [R9]

  // Each cell keeps its own previous level, so edge detection shares no state
  // The mode is decoded per pin from style, edge select and enable
  // One edge cell per implemented pin
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      if (gi < NPINS) begin : g_used
        pcn_edge_cell u_cell (
          .i_clk(i_clk),
          .i_resetn(i_resetn),
          .i_level(pins16[gi]),
          .i_mode(pcn_pin_mode(cfg.style, cfg.edge_sel[gi], cfg.pin_en[gi])), // [R5] [R6] [R7]
          .i_armed(armed[gi]),
          .i_clr(flag_clr[gi]),
          .o_flag(flags[gi]),
          .o_set(flag_set[gi])
        );
      end else begin : g_none
        // Absent pins tie off to no event
        assign flags[gi] = 1'b0;
        assign flag_set[gi] = 1'b0;
      end
    end
  endgenerate

  // Snapshot of the pins taken whenever software reads the port
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_read_ff <= 16'h0000;
    end else if (port_rd) begin
      // Snapshot is the value the read returned, so a change after setup is not lost
      last_read_ff <= prdata_ff[15:0]; // [R10]
    end
  end

  // A bit holds until software reads the port again,
  // Even if the pin returns to the level of the snapshot
  // Mismatch: set while the pin differs from its snapshot, held until the next port read
  always_comb begin
    nxt_mismatch = mismatch_ff;
    if (port_rd) begin
      nxt_mismatch = 16'h0000; // Read restarts the comparison
    end
    // Only armed pins in mismatch mode compare; others keep their bit
    for (int i = 0; i < 16; i++) begin
      if (pcn_pin_mode(cfg.style, cfg.edge_sel[i], cfg.pin_en[i]) == PCN_MODE_MISMATCH &&
          armed[i] && !port_rd && pins16[i] != last_read_ff[i]) begin
        nxt_mismatch[i] = 1'b1; // [R4] [R10]
      end
    end
  end

  // Mismatch status; bits clear when software reads the port input
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mismatch_ff <= 16'h0000;
    end else begin
      mismatch_ff <= nxt_mismatch;
    end
  end

  assign mism_new = nxt_mismatch & ~mismatch_ff;

  // Detection needs only the clocked synchronisers, never bus traffic
  assign irq_evt[`PCN_IRQ_EDGE_BIT] = |flag_set; // [R2]
  assign irq_evt[`PCN_IRQ_MISM_BIT] = |mism_new;

  // Mask resets to zero so no interrupt leaves before software asks
  // Interrupt mask
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask_ff <= `PCN_RST_IRQ;
    end else if (wr_acc && i_paddr == `PCN_OFS_IRQ_MASK) begin
      irq_mask_ff <= i_pwdata[`PCN_IRQ_W-1:0];
    end
  end

  // Bit 0 records any new edge flag, bit 1 any newly set mismatch bit
  // Sticky causes, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_ff <= `PCN_RST_IRQ;
    end else begin
      for (int i = 0; i < `PCN_IRQ_W; i++) begin
        if (irq_evt[i]) begin
          irq_stat_ff[i] <= 1'b1;
        // Software clear applies only when no new event lands this clock
        end else if (wr_acc && i_paddr == `PCN_OFS_IRQ_STAT && i_pwdata[i]) begin
          irq_stat_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Level output; stays high until the cause is cleared or masked
  assign o_irq = |(irq_stat_ff & irq_mask_ff);

  // Gated by the port enable, so turning the port off silences it at once
  // Change request follows the bits of the selected style
  assign o_cn_req = cfg.on & (cfg.style ? |flags : |mismatch_ff); // [R15] [R14]

endmodule

/* rtl/pcn_map.svh */
// Register offsets, field positions, reset values and timing for the port change notifier
// Notes on behaviour
// R1: Detection runs only while port enable bit set
// R2: Detection must work without bus or CPU activity
// R3: Each pin individually enabled as change source
// R4: Mismatch style: enabled pin flags last-read mismatch
// R5: Edge style, select 0 enable 1: rising only
// R6: Edge style, select 1 enable 0: falling only
// R7: Edge style, both bits set: both edges
// R8: Edge style at bit 11 sets pin flag
// R9: Flags stay set until software clears them
// R10: Mismatch bit means changed since last read
// R11: Only pins configured as inputs raise events
// R12: Edge select register has one bit per pin
// R13: Software disables pulls on output pins
// R14: Style bit picks mismatch bits or flag bits
// R15: Request output high while enabled events pending
`ifndef PCN_MAP_SVH
`define PCN_MAP_SVH

// Byte offsets on the register bus
`define PCN_OFS_CTRL 8'h00
`define PCN_OFS_PIN_EN 8'h04
`define PCN_OFS_EDGE_SEL 8'h08
`define PCN_OFS_MISMATCH 8'h0C
`define PCN_OFS_FLAGS 8'h10
`define PCN_OFS_PORT_IN 8'h14
`define PCN_OFS_DIR 8'h18
`define PCN_OFS_IRQ_MASK 8'h1C
`define PCN_OFS_IRQ_STAT 8'h20

// Control register fields
`define PCN_CTRL_ON_BIT 15
`define PCN_CTRL_STYLE_BIT 11

// Interrupt status fields
`define PCN_IRQ_EDGE_BIT 0
`define PCN_IRQ_MISM_BIT 1
`define PCN_IRQ_W 2

// Reset values
`define PCN_RST_CTRL 16'h0000
`define PCN_RST_PIN_EN 16'h0000
`define PCN_RST_EDGE_SEL 16'h0000
`define PCN_RST_FLAGS 16'h0000
`define PCN_RST_DIR 16'hFFFF
`define PCN_RST_IRQ 2'h0

// Synchroniser depth in flops
`define PCN_SYNC_STAGES 2

`endif

/* rtl/pcn_pkg.sv */
// Types shared by the port change notifier
package pcn_pkg;

  // Per-pin detection mode, one-hot
  typedef enum logic [4:0] {
    PCN_MODE_OFF = 5'b00001,
    PCN_MODE_MISMATCH = 5'b00010,
    PCN_MODE_RISE = 5'b00100,
    PCN_MODE_FALL = 5'b01000,
    PCN_MODE_BOTH = 5'b10000
  } pcn_mode_t;

  // Software configuration that steers detection
  typedef struct packed {
    logic on;
    logic style;
    logic [15:0] pin_en;
    logic [15:0] edge_sel;
    logic [15:0] dir;
  } pcn_cfg_t;

  // Mode decode from style, edge select and pin enable
  function automatic pcn_mode_t pcn_pin_mode(input logic style, input logic esel, input logic pen);
    pcn_mode_t m;
    m = PCN_MODE_OFF;
    if (!style) begin
      m = pen ? PCN_MODE_MISMATCH : PCN_MODE_OFF;
    end else begin
      case ({esel, pen})
        2'b01: m = PCN_MODE_RISE;
        2'b10: m = PCN_MODE_FALL;
        2'b11: m = PCN_MODE_BOTH;
        default: m = PCN_MODE_OFF;
      endcase
    end
    return m;
  endfunction

endpackage

/* rtl/pcn_sync.sv */
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module pcn_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Raw and synchronised levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff; // First stage, read only by the second
  logic [W-1:0] sync_ff; // Second stage, safe to use

  initial begin
    if (W < 1) begin
      $error("pcn_sync width must be at least one");
    end
  end

  // Both stages; each pin crosses on its own, no bus coherency implied
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

/* rtl/pcn_edge_cell.sv */
// Edge detector and sticky event flag for one pin
`timescale 1ns/1ps
module pcn_edge_cell
  import pcn_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Synchronised level and configuration
  input wire logic i_level,
  input pcn_mode_t i_mode,
  input wire logic i_armed,
  // Software clear and flag
  input wire logic i_clr,
  output logic o_flag,
  output logic o_set
);

  logic prev_ff; // Level seen one clock earlier
  logic flag_ff; // Sticky event flag
  logic rise; // Rising transition this clock
  logic fall; // Falling transition this clock
  logic hit; // Enabled edge this clock

  assign rise = i_level & ~prev_ff;
  assign fall = ~i_level & prev_ff;

  // Qualify edges by mode
  always_comb begin
    hit = 1'b0;
    case (i_mode)
      PCN_MODE_RISE: hit = rise; // [R5]
      PCN_MODE_FALL: hit = fall; // [R6]
      PCN_MODE_BOTH: hit = rise | fall; // [R7]
      default: hit = 1'b0; // Off or mismatch style sets no flag
    endcase
  end

  assign o_set = hit & i_armed;

  // Previous level tracks always so enabling gives no false edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= i_level;
    end
  end

  // Flag stays until cleared; a new edge beats a clear in the same clock
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_ff <= 1'b0;
    end else if (o_set) begin
      flag_ff <= 1'b1; // [R8] [R9]
    end else if (i_clr) begin
      flag_ff <= 1'b0;
    end
  end

  assign o_flag = flag_ff;

endmodule

/* verif/pcn_top_properties.sv */
// Port-level assertions for the port change notifier
`timescale 1ns/1ps
module pcn_top_props
  import pcn_pkg::*;
#(
  parameter int NPINS = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave side
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pins and requests
  input wire logic [NPINS-1:0] i_pins,
  input wire logic o_cn_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Access phase of any transfer
  logic acc;
  assign acc = i_psel && i_penable;
  // Error only while a transfer is in its access phase
  err_in_access_a: assert property (o_pslverr |-> acc && (i_paddr > 8'h20 || i_paddr[1:0] != 2'h0))
    else $error("pslverr outside an unmapped access");
  err_unmapped_a: assert property (acc && i_paddr > 8'h20 |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (acc && i_paddr <= 8'h20 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access refused");
  rd_upper_a: assert property (acc && !i_pwrite |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // A new request needs a pin change or a recent bus access as its cause
  req_cause_a: assert property ($rose(o_cn_req) |-> $past(i_pins, 2) != $past(i_pins, 5) || $past(acc) || $past(acc, 2))
    else $error("request rose without cause");
  irq_cause_a: assert property ($rose(o_irq) |-> $past(i_pins, 2) != $past(i_pins, 5) || $past(acc) || $past(acc, 2))
    else $error("irq rose without cause");
  // Sticky state drops only after software touched the registers
  req_sticky_a: assert property ($fell(o_cn_req) |-> $past(acc)) else $error("request dropped alone");
  irq_sticky_a: assert property ($fell(o_irq) |-> $past(acc)) else $error("irq dropped alone");
  // Main scenarios reached
  cover property ($rose(o_cn_req));
  cover property ($rose(o_irq));
  cover property (o_pslverr);
endmodule
bind pcn_top pcn_top_props #(.NPINS(NPINS)) u_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pins(i_pins), .o_cn_req(o_cn_req), .o_irq(o_irq));

/* verif/pcn_pin_model.sv */
// External pin drivers facing the port change notifier
`timescale 1ns/1ps
module pcn_pin_model (
  // Clock
  input wire logic i_clk,
  // Requested levels and driven pins
  input wire logic [15:0] i_lvl,
  output logic [15:0] o_pins
);
  // Pins driven hard both ways, so no pulls are relied on
  initial o_pins = 16'h0000;
  // Levels change only after an edge, like real board logic
  always @(posedge i_clk) begin
    o_pins <= i_lvl;
  end
endmodule

/* verif/tb.sv */
// Register-level testbench for the port change notifier
`timescale 1ns/1ps
`include "pcn_map.svh"
module tb;
  import pcn_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] pins;
  logic cn_req;
  logic irq;
  // Bus answer as it stood at the last edge
  logic [31:0] s_rd;
  logic s_err;
  int fails = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;

  pcn_pin_model u_pins (.i_clk(clk), .i_lvl(lvl), .o_pins(pins));
  pcn_top #(.NPINS(16)) dut (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pins(pins), .o_cn_req(cn_req), .o_irq(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits on pready under a bounded count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // Answer taken at the edge where pready is high, before that edge updates anything
    s_rd = prdata;
    s_err = pslverr;
    if (pready !== 1'b1) begin
      fails++;
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, s_rd, exp);
  endtask

  // Pin model edge plus synchroniser and detect edges
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 160 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and an unmapped address
    rd(`PCN_OFS_CTRL, 32'h0, "ctrl");
    rd(`PCN_OFS_PIN_EN, 32'h0, "pin_en");
    rd(`PCN_OFS_EDGE_SEL, 32'h0, "edge_sel");
    rd(`PCN_OFS_FLAGS, 32'h0, "flags");
    rd(`PCN_OFS_MISMATCH, 32'h0, "mismatch");
    rd(`PCN_OFS_DIR, 32'h0000FFFF, "dir");
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", {31'h0, s_err}, 32'h1);
    // Pins 0..3 set to off, rise, fall, both
    wr(`PCN_OFS_PIN_EN, 32'h000A);
    wr(`PCN_OFS_EDGE_SEL, 32'h000C);
    wr(`PCN_OFS_IRQ_MASK, 32'h1);
    wr(`PCN_OFS_CTRL, 32'h8800);
    lvl <= 16'h000F;
    settle();
    rd(`PCN_OFS_FLAGS, 32'h000A, "flags rise");
    chk("req", {31'h0, cn_req}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(`PCN_OFS_IRQ_STAT, 32'h1, "irq_stat");
    // Falling edges add to the flags already held
    lvl <= 16'h0000;
    settle();
    rd(`PCN_OFS_FLAGS, 32'h000E, "flags fall");
    wr(`PCN_OFS_FLAGS, 32'hF);
    wr(`PCN_OFS_IRQ_STAT, 32'h3);
    rd(`PCN_OFS_FLAGS, 32'h0, "flags clr");
    chk("req clr", {31'h0, cn_req}, 32'h0);
    chk("irq clr", {31'h0, irq}, 32'h0);
    // Output pin and a disabled port stay silent
    wr(`PCN_OFS_DIR, 32'hFFFD);
    lvl <= 16'h0002;
    settle();
    rd(`PCN_OFS_FLAGS, 32'h0, "flags out");
    wr(`PCN_OFS_DIR, 32'hFFFF);
    wr(`PCN_OFS_CTRL, 32'h0800);
    lvl <= 16'h0008;
    settle();
    rd(`PCN_OFS_FLAGS, 32'h0, "flags off");
    // Masked interrupt while a flag is pending
    wr(`PCN_OFS_IRQ_MASK, 32'h0);
    wr(`PCN_OFS_CTRL, 32'h8800);
    lvl <= 16'h0000;
    settle();
    rd(`PCN_OFS_FLAGS, 32'h0008, "flags both");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`PCN_OFS_FLAGS, 32'hF);
    wr(`PCN_OFS_IRQ_STAT, 32'h3);
    // Mismatch style on pin 4, pin 5 not enabled
    wr(`PCN_OFS_PIN_EN, 32'h0010);
    wr(`PCN_OFS_CTRL, 32'h8000);
    wr(`PCN_OFS_IRQ_MASK, 32'h2);
    rd(`PCN_OFS_PORT_IN, 32'h0, "port_in");
    // Pin 2 has an edge select but no enable, so it stays silent too
    lvl <= 16'h0034;
    settle();
    rd(`PCN_OFS_MISMATCH, 32'h0010, "mismatch");
    rd(`PCN_OFS_FLAGS, 32'h0, "flags mism");
    chk("req mism", {31'h0, cn_req}, 32'h1);
    chk("irq mism", {31'h0, irq}, 32'h1);
    rd(`PCN_OFS_PORT_IN, 32'h0034, "port_in new");
    rd(`PCN_OFS_MISMATCH, 32'h0, "mismatch clr");
    chk("req read", {31'h0, cn_req}, 32'h0);
    wr(`PCN_OFS_IRQ_STAT, 32'h2);
    @(posedge clk);
    chk("irq w1c", {31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
